// *** src/pwr_seq_pkg.sv ***
// Constants, register map and state encoding for the power-state sequencer.
// Assumes a single clock domain and an AXI4-Lite master on the register side.
package pwr_seq_pkg;

    // AXI4-Lite geometry
    localparam int          ADDR_W    = 4;
    localparam int          DATA_W    = 32;
    localparam logic [1:0]  RESP_OK   = 2'h0;
    localparam logic [1:0]  RESP_ERR  = 2'h2;

    // Register byte addresses
    localparam logic [3:0]  CTRL_ADDR  = 4'h0;
    localparam logic [3:0]  STAT_ADDR  = 4'h4;
    localparam logic [3:0]  IRQS_ADDR  = 4'h8;
    localparam logic [3:0]  IRQM_ADDR  = 4'hC;

    // Control register fields
    localparam int          CTRL_MGMT_EXIT = 0;

    // Status register fields
    localparam int          ST_STOPGNT  = 0;
    localparam int          ST_SLEEP    = 1;
    localparam int          ST_MGMT     = 2;
    localparam int          ST_TRIP     = 3;
    localparam int          ST_TERM     = 4;
    localparam int          ST_EDGE     = 5;
    localparam int          ST_INTPEND  = 6;
    localparam int          STAT_W      = 7;

    // Interrupt event bits
    localparam int          EV_STOPGNT  = 0;
    localparam int          EV_SLEEP    = 1;
    localparam int          EV_MGMT     = 2;
    localparam int          EV_TRIP     = 3;
    localparam int          EV_RESUME   = 4;
    localparam int          EV_W        = 5;
    localparam logic [4:0]  IRQM_RESET  = 5'h00;

    // Asynchronous input bit positions
    localparam int          AS_SLEEP    = 0;
    localparam int          AS_STOP     = 1;
    localparam int          AS_MGMT     = 2;
    localparam int          AS_HOT      = 3;
    localparam int          AS_INTR     = 4;
    localparam int          AS_TERM     = 5;
    localparam int          AS_EDGE     = 6;
    localparam int          AS_W        = 7;

    // Acknowledge bus transaction codes
    localparam logic [1:0]  ACK_NONE    = 2'h0;
    localparam logic [1:0]  ACK_STOPGNT = 2'h1;
    localparam logic [1:0]  ACK_MGMT    = 2'h2;

    // Power state machine
    typedef enum logic [2:0] {
        PS_RUN,
        PS_SG_ACK,
        PS_STOP_GRANT,
        PS_SLEEP,
        PS_MGMT_ACK
    } pwr_state_e;

endpackage

// *** src/cpu_power_state_thermal_trip.sv ***
// Power-state sequencer: stop-grant, sleep, management mode, thermal halt.
// Assumes one bus clock, synchronous reset and an AXI4-Lite register master.
module cpu_power_state_thermal_trip (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_SYS_RST,
    input  wire logic        I_CLK_EN,
    input  wire logic        I_SLEEP_REQUEST_N,
    input  wire logic        I_STOP_CLOCK_REQUEST_N,
    input  wire logic        I_MGMT_INTERRUPT_N,
    input  wire logic        I_OVER_TEMP,
    input  wire logic        I_INTR_REQ,
    input  wire logic        I_TERMINATION_SENSE_STRAP,
    input  wire logic        I_EDGE_RATE_STRAP,
    input  wire logic        I_TARGET_READY_N,
    input  wire logic        I_SNOOP_REQ,
    output logic             O_SNOOP_ACK,
    output logic             O_ACK_REQ,
    output logic [1:0]       O_ACK_CODE,
    output logic             O_CORE_CLK_EN,
    output logic             O_BUS_CLK_EN,
    output logic             O_LOCAL_INTR_CLK_EN,
    output logic             O_EXEC_EN,
    output logic             O_SAVE_STATE,
    output logic             O_MANAGEMENT_MODE,
    output logic             O_INTR_SERVICE,
    output logic             O_THERMAL_HALT_N,
    output logic             O_TERM_PRESENT,
    output logic             O_EDGE_RATE,
    output logic             O_IRQ,
    input  wire logic [3:0]  I_AWADDR,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    input  wire logic [3:0]  I_ARADDR,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY
);

    localparam int AW = pwr_seq_pkg::AS_W;
    localparam int EW = pwr_seq_pkg::EV_W;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronizers

    logic [AW-1:0] async_in;
    logic [AW-1:0] sync1;
    logic [AW-1:0] sync2;

    // Gather pins that arrive from outside the clock domain
    assign async_in = {I_EDGE_RATE_STRAP, I_TERMINATION_SENSE_STRAP, I_INTR_REQ,
                       I_OVER_TEMP, I_MGMT_INTERRUPT_N, I_STOP_CLOCK_REQUEST_N,
                       I_SLEEP_REQUEST_N};

    // Two flops per bit, unreset so a hot die is seen during reset
    genvar g;
    generate
        for (g = 0; g < AW; g++) begin : g_sync
            always_ff @(posedge I_CORE_CLK) begin
                if (I_CLK_EN) begin
                    sync1[g] <= async_in[g];
                    sync2[g] <= sync1[g];
                end
            end
        end
    endgenerate

    logic sleep_req;
    logic stop_req;
    logic mgmt_lvl;
    logic hot;
    logic intr_lvl;
    logic mgmt_prev;
    logic intr_prev;

    // Active-high views of the synchronised levels
    assign sleep_req = ~sync2[pwr_seq_pkg::AS_SLEEP];
    assign stop_req  = ~sync2[pwr_seq_pkg::AS_STOP];
    assign mgmt_lvl  = ~sync2[pwr_seq_pkg::AS_MGMT];
    assign hot       = sync2[pwr_seq_pkg::AS_HOT];
    assign intr_lvl  = sync2[pwr_seq_pkg::AS_INTR];

    ////////////////////////////////////////////////////////////////////////////
    // Straps and thermal trip latch

    logic term_present;
    logic edge_rate;
    logic trip;

    // Straps follow the pins during reset and freeze at release
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            term_present <= sync2[pwr_seq_pkg::AS_TERM];
            edge_rate    <= sync2[pwr_seq_pkg::AS_EDGE];
        end
    end

    // Trip latch: reset clears only a cooled die
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            trip <= hot;
        end else if (I_CLK_EN && hot) begin
            trip <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power state machine

    pwr_seq_pkg::pwr_state_e state;
    pwr_seq_pkg::pwr_state_e next_state;
    logic       mgmt_pend;
    logic       int_pend;
    logic       mgmt_mode;
    logic       mgmt_exit;
    logic       ack_taken;
    logic       mgmt_edge;
    logic       intr_edge;
    logic       asleep;
    logic       serve_int;
    logic       take_mgmt;

    assign asleep    = (state == pwr_seq_pkg::PS_SLEEP);
    assign ack_taken = O_ACK_REQ & ~I_TARGET_READY_N;
    assign mgmt_edge = mgmt_lvl & ~mgmt_prev & ~asleep;
    assign intr_edge = intr_lvl & ~intr_prev & ~asleep;
    assign take_mgmt = (state == pwr_seq_pkg::PS_RUN) & ~stop_req
                     & mgmt_pend & ~mgmt_mode;
    assign serve_int = (state == pwr_seq_pkg::PS_RUN) & int_pend & ~trip;

    // Next power state
    always_comb begin
        next_state = state;
        case (state)
            pwr_seq_pkg::PS_RUN: begin
                if (stop_req) begin
                    next_state = pwr_seq_pkg::PS_SG_ACK;
                end else if (take_mgmt) begin
                    next_state = pwr_seq_pkg::PS_MGMT_ACK;
                end
            end
            pwr_seq_pkg::PS_SG_ACK: begin
                if (ack_taken) begin
                    next_state = pwr_seq_pkg::PS_STOP_GRANT;
                end
            end
            pwr_seq_pkg::PS_STOP_GRANT: begin
                if (sleep_req) begin
                    next_state = pwr_seq_pkg::PS_SLEEP;
                end else if (!stop_req) begin
                    next_state = pwr_seq_pkg::PS_RUN;
                end
            end
            pwr_seq_pkg::PS_SLEEP: begin
                if (!sleep_req) begin
                    next_state = pwr_seq_pkg::PS_STOP_GRANT;
                end
            end
            pwr_seq_pkg::PS_MGMT_ACK: begin
                if (ack_taken) begin
                    next_state = pwr_seq_pkg::PS_RUN;
                end
            end
            default: next_state = pwr_seq_pkg::PS_RUN;
        endcase
    end
    // Sleep request is only looked at from stop-grant and sleep

    // State register and pending flags; new arrivals beat clears
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            state     <= pwr_seq_pkg::PS_RUN;
            mgmt_prev <= 1'b0;
            intr_prev <= 1'b0;
            mgmt_pend <= 1'b0;
            int_pend  <= 1'b0;
            mgmt_mode <= 1'b0;
        end else if (I_CLK_EN) begin
            state     <= next_state;
            mgmt_prev <= mgmt_lvl;
            intr_prev <= intr_lvl;
            mgmt_pend <= mgmt_edge | (mgmt_pend & ~take_mgmt);
            int_pend  <= intr_edge | (int_pend & ~serve_int);
            mgmt_mode <= take_mgmt | (mgmt_mode & ~mgmt_exit);
        end
    end

    // Acknowledge transaction, held until the target takes it
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            O_ACK_REQ  <= 1'b0;
            O_ACK_CODE <= pwr_seq_pkg::ACK_NONE;
        end else if (I_CLK_EN) begin
            if (ack_taken) begin
                O_ACK_REQ  <= 1'b0;
                O_ACK_CODE <= pwr_seq_pkg::ACK_NONE;
            end else if (state == pwr_seq_pkg::PS_RUN && stop_req) begin
                O_ACK_REQ  <= 1'b1;
                O_ACK_CODE <= pwr_seq_pkg::ACK_STOPGNT;
            end else if (take_mgmt) begin
                O_ACK_REQ  <= 1'b1;
                O_ACK_CODE <= pwr_seq_pkg::ACK_MGMT;
            end
        end
    end

    // Clock gates, execution and pin outputs
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            O_CORE_CLK_EN       <= 1'b0;
            O_BUS_CLK_EN        <= 1'b0;
            O_LOCAL_INTR_CLK_EN <= 1'b0;
            O_EXEC_EN           <= 1'b0;
            O_SAVE_STATE        <= 1'b0;
            O_INTR_SERVICE      <= 1'b0;
            O_SNOOP_ACK         <= 1'b0;
            O_MANAGEMENT_MODE   <= 1'b0;
            O_THERMAL_HALT_N    <= 1'b0;
            O_TERM_PRESENT      <= 1'b0;
            O_EDGE_RATE         <= 1'b0;
        end else if (I_CLK_EN) begin
            O_CORE_CLK_EN       <= ~asleep & (state != pwr_seq_pkg::PS_STOP_GRANT);
            O_BUS_CLK_EN        <= ~asleep;
            O_LOCAL_INTR_CLK_EN <= ~asleep;
            O_EXEC_EN           <= (state == pwr_seq_pkg::PS_RUN) & ~trip;
            O_SAVE_STATE        <= take_mgmt;
            O_INTR_SERVICE      <= serve_int;
            O_SNOOP_ACK         <= I_SNOOP_REQ & ~asleep;
            O_MANAGEMENT_MODE   <= mgmt_mode;
            O_THERMAL_HALT_N    <= ~trip;
            O_TERM_PRESENT      <= term_present;
            O_EDGE_RATE         <= edge_rate;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    logic [EW-1:0] events;
    logic [EW-1:0] irq_stat;
    logic [EW-1:0] irq_mask;
    logic          rd_clr;
    logic          wr_mask;
    logic          entering;
    logic [31:0]   wdata_now;

    assign entering = (next_state != state);

    // One-cycle event strobes from state changes and from a hot die before the trip latch sets
    assign events[pwr_seq_pkg::EV_STOPGNT] = entering
                                           & (next_state == pwr_seq_pkg::PS_STOP_GRANT)
                                           & (state == pwr_seq_pkg::PS_SG_ACK);
    assign events[pwr_seq_pkg::EV_SLEEP]   = entering & (next_state == pwr_seq_pkg::PS_SLEEP);
    assign events[pwr_seq_pkg::EV_MGMT]    = take_mgmt;
    assign events[pwr_seq_pkg::EV_TRIP]    = hot & ~trip;
    assign events[pwr_seq_pkg::EV_RESUME]  = entering & (next_state == pwr_seq_pkg::PS_RUN)
                                           & (state == pwr_seq_pkg::PS_STOP_GRANT);

    // Sticky status, read clears, new event wins
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            irq_stat <= '0;
            irq_mask <= pwr_seq_pkg::IRQM_RESET;
            O_IRQ    <= 1'b0;
        end else if (I_CLK_EN) begin
            irq_stat <= events | (irq_stat & {EW{~rd_clr}});
            if (wr_mask) begin
                irq_mask <= wdata_now[EW-1:0];
            end
            O_IRQ    <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    logic        aw_got;
    logic        w_got;
    logic [3:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        aw_fire;
    logic        w_fire;
    logic        ar_fire;
    logic        wr_do;
    logic [3:0]  waddr_now;
    logic [3:0]  wstrb_now;
    logic        next_aw_got;
    logic        next_w_got;
    logic        next_bvalid;
    logic        next_rvalid;
    logic        wr_hit;
    logic        rd_hit;
    localparam int STAT_W = pwr_seq_pkg::STAT_W;

    logic [31:0] rd_val;
    logic [STAT_W-1:0] stat_val;

    // Handshakes and held write payload
    assign aw_fire   = I_AWVALID & O_AWREADY;
    assign w_fire    = I_WVALID & O_WREADY;
    assign ar_fire   = I_ARVALID & O_ARREADY;
    assign waddr_now = aw_fire ? I_AWADDR : waddr;
    assign wdata_now = w_fire ? I_WDATA : wdata;
    assign wstrb_now = w_fire ? I_WSTRB : wstrb;
    assign wr_do     = (aw_got | aw_fire) & (w_got | w_fire) & ~O_BVALID;

    assign next_aw_got = ~wr_do & (aw_got | aw_fire);
    assign next_w_got  = ~wr_do & (w_got | w_fire);
    assign next_bvalid = wr_do | (O_BVALID & ~I_BREADY);
    assign next_rvalid = ar_fire | (O_RVALID & ~I_RREADY);

    // Write decode
    assign wr_hit    = (waddr_now == pwr_seq_pkg::CTRL_ADDR)
                     | (waddr_now == pwr_seq_pkg::IRQS_ADDR)
                     | (waddr_now == pwr_seq_pkg::IRQM_ADDR)
                     | (waddr_now == pwr_seq_pkg::STAT_ADDR);
    assign mgmt_exit = wr_do & wstrb_now[0]
                     & (waddr_now == pwr_seq_pkg::CTRL_ADDR)
                     & wdata_now[pwr_seq_pkg::CTRL_MGMT_EXIT];
    assign wr_mask   = wr_do & wstrb_now[0] & (waddr_now == pwr_seq_pkg::IRQM_ADDR);

    // Status word
    assign stat_val = {int_pend, edge_rate, term_present, trip, mgmt_mode,
                       asleep, (state == pwr_seq_pkg::PS_STOP_GRANT)};

    // Read decode
    assign rd_hit = (I_ARADDR == pwr_seq_pkg::CTRL_ADDR)
                  | (I_ARADDR == pwr_seq_pkg::STAT_ADDR)
                  | (I_ARADDR == pwr_seq_pkg::IRQS_ADDR)
                  | (I_ARADDR == pwr_seq_pkg::IRQM_ADDR);
    assign rd_val = (I_ARADDR == pwr_seq_pkg::STAT_ADDR) ? {{(32-STAT_W){1'b0}}, stat_val}
                  : (I_ARADDR == pwr_seq_pkg::IRQS_ADDR) ? {{(32-EW){1'b0}}, irq_stat}
                  : (I_ARADDR == pwr_seq_pkg::IRQM_ADDR) ? {{(32-EW){1'b0}}, irq_mask}
                  : '0;
    assign rd_clr = ar_fire & (I_ARADDR == pwr_seq_pkg::IRQS_ADDR);

    // Write channel registers
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            waddr     <= '0;
            wdata     <= '0;
            wstrb     <= '0;
            O_AWREADY <= 1'b0;
            O_WREADY  <= 1'b0;
            O_BVALID  <= 1'b0;
            O_BRESP   <= pwr_seq_pkg::RESP_OK;
        end else if (I_CLK_EN) begin
            aw_got    <= next_aw_got;
            w_got     <= next_w_got;
            waddr     <= waddr_now;
            wdata     <= wdata_now;
            wstrb     <= wstrb_now;
            O_AWREADY <= ~next_aw_got & ~next_bvalid;
            O_WREADY  <= ~next_w_got & ~next_bvalid;
            O_BVALID  <= next_bvalid;
            if (wr_do) begin
                O_BRESP <= wr_hit ? pwr_seq_pkg::RESP_OK : pwr_seq_pkg::RESP_ERR;
            end
        end
    end

    // Read channel registers
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b0;
            O_RDATA   <= '0;
            O_RRESP   <= pwr_seq_pkg::RESP_OK;
        end else if (I_CLK_EN) begin
            O_ARREADY <= ~next_rvalid;
            O_RVALID  <= next_rvalid;
            if (ar_fire) begin
                O_RDATA <= rd_val;
                O_RRESP <= rd_hit ? pwr_seq_pkg::RESP_OK : pwr_seq_pkg::RESP_ERR;
            end
        end
    end

endmodule // cpu_power_state_thermal_trip

// *** dv/cpu_power_state_thermal_trip_props.sv ***
// Port assertions for the power-state sequencer.
// Assumes one clock domain; bound to the top module below.
module pwr_seq_props (
    input wire logic       I_CORE_CLK,
    input wire logic       I_SYS_RST,
    input wire logic       I_STOP_CLOCK_REQUEST_N,
    input wire logic       I_TARGET_READY_N,
    input wire logic       I_SNOOP_REQ,
    input wire logic       O_SNOOP_ACK,
    input wire logic       O_ACK_REQ,
    input wire logic [1:0] O_ACK_CODE,
    input wire logic       O_CORE_CLK_EN,
    input wire logic       O_BUS_CLK_EN,
    input wire logic       O_LOCAL_INTR_CLK_EN,
    input wire logic       O_EXEC_EN,
    input wire logic       O_SAVE_STATE,
    input wire logic       O_MANAGEMENT_MODE,
    input wire logic       O_THERMAL_HALT_N
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SYS_RST);
    logic [1:0] age;
    // Edges since reset release, saturating
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) age <= 2'h0;
        else if (age != 2'h3) age <= age + 2'h1;
    end
    ////////////////////////////////////////
    ack_hold_a: assert property (O_ACK_REQ && I_TARGET_READY_N |=>
        O_ACK_REQ && $stable(O_ACK_CODE)) else $error("ack dropped early");
    sync_delay_a: assert property ($fell(I_STOP_CLOCK_REQUEST_N) &&
        O_ACK_CODE != pwr_seq_pkg::ACK_STOPGNT |=> O_ACK_CODE != pwr_seq_pkg::ACK_STOPGNT)
        else $error("stop ack too soon");
    halt_latch_a: assert property (age[1] && !O_THERMAL_HALT_N |=> !O_THERMAL_HALT_N)
        else $error("halt released");
    halt_stop_a: assert property (!O_THERMAL_HALT_N |-> !O_EXEC_EN)
        else $error("runs while halted");
    core_gate_a: assert property (!O_CORE_CLK_EN |-> !O_EXEC_EN)
        else $error("runs while gated");
    sleep_gate_a: assert property (!O_BUS_CLK_EN |-> !O_CORE_CLK_EN)
        else $error("core clock in sleep");
    unit_pair_a: assert property (age[1] |-> O_BUS_CLK_EN == O_LOCAL_INTR_CLK_EN)
        else $error("bus and interrupt unit clocks differ");
    snoop_quiet_a: assert property (age[1] && !$past(O_BUS_CLK_EN) && !O_BUS_CLK_EN
        |-> !O_SNOOP_ACK) else $error("snoop answered asleep");
    snoop_live_a: assert property (I_SNOOP_REQ && O_BUS_CLK_EN |=>
        O_SNOOP_ACK || !O_BUS_CLK_EN) else $error("snoop missed");
    save_mode_a: assert property (O_SAVE_STATE |=> !O_SAVE_STATE && O_MANAGEMENT_MODE)
        else $error("save pulse wrong");
    mgmt_ack_a: assert property ($rose(O_SAVE_STATE) |-> ##[0:1]
        (O_ACK_REQ && O_ACK_CODE == pwr_seq_pkg::ACK_MGMT)) else $error("no mgmt ack");
    cover property (O_BUS_CLK_EN && !O_CORE_CLK_EN);
    cover property (!O_BUS_CLK_EN);
    cover property (O_SAVE_STATE);
    cover property (!O_THERMAL_HALT_N);
endmodule // pwr_seq_props

bind cpu_power_state_thermal_trip pwr_seq_props u_props (
    .I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST),
    .I_STOP_CLOCK_REQUEST_N(I_STOP_CLOCK_REQUEST_N), .I_TARGET_READY_N(I_TARGET_READY_N),
    .I_SNOOP_REQ(I_SNOOP_REQ), .O_SNOOP_ACK(O_SNOOP_ACK), .O_ACK_REQ(O_ACK_REQ),
    .O_ACK_CODE(O_ACK_CODE), .O_CORE_CLK_EN(O_CORE_CLK_EN), .O_BUS_CLK_EN(O_BUS_CLK_EN),
    .O_LOCAL_INTR_CLK_EN(O_LOCAL_INTR_CLK_EN), .O_EXEC_EN(O_EXEC_EN),
    .O_SAVE_STATE(O_SAVE_STATE), .O_MANAGEMENT_MODE(O_MANAGEMENT_MODE),
    .O_THERMAL_HALT_N(O_THERMAL_HALT_N));

// *** dv/chipset_model.sv ***
// Bus target model that takes acknowledge transactions.
// Assumes the sequencer's clock and synchronous reset.
module chipset_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ack_req,
    input  wire logic [1:0] i_ack_code,
    input  wire logic [2:0] i_delay,
    output logic            o_target_ready_n,
    output logic [1:0]      o_last_code
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] wait_cnt;
    // Ready after a chosen wait, one cycle low
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_target_ready_n <= 1'b1;
            o_last_code      <= 2'h0;
            wait_cnt         <= 3'h0;
        end else if (i_ack_req && o_target_ready_n) begin
            if (wait_cnt >= i_delay) begin
                o_target_ready_n <= 1'b0;
                o_last_code      <= i_ack_code;
                wait_cnt         <= 3'h0;
            end else wait_cnt <= wait_cnt + 3'h1;
        end else o_target_ready_n <= 1'b1;
    end
endmodule // chipset_model

// *** dv/test_cpu_power_state_thermal_trip.sv ***
// Self-checking bench for the power-state sequencer.
// Assumes the chipset model and the bound port checker.
module test_cpu_power_state_thermal_trip;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, slp_n = 1, stop_n = 1, smi_n = 1, hot = 0, intr = 0;
    logic term = 0, edge_s = 0, snoop = 0, target_ready_n_n, awvalid = 0, wvalid = 0;
    logic bready = 0, arvalid = 0, rready = 0, snoop_ack, ack_req, core_en, bus_en;
    logic lic_en, exec_en, save, mgmt, isrv, halt_n, term_p, edge_r, irq;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0]  ack_code, bresp, rresp, last_code;
    logic [2:0]  delay = 3'h0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    int failures = 0, checks = 0, serviced = 0, seed = 23696;
    always #12.5 clk = ~clk;
    cpu_power_state_thermal_trip dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(1'b1),
        .I_SLEEP_REQUEST_N(slp_n), .I_STOP_CLOCK_REQUEST_N(stop_n), .I_MGMT_INTERRUPT_N(smi_n),
        .I_OVER_TEMP(hot), .I_INTR_REQ(intr), .I_TERMINATION_SENSE_STRAP(term),
        .I_EDGE_RATE_STRAP(edge_s), .I_TARGET_READY_N(target_ready_n_n), .I_SNOOP_REQ(snoop),
        .O_SNOOP_ACK(snoop_ack), .O_ACK_REQ(ack_req), .O_ACK_CODE(ack_code),
        .O_CORE_CLK_EN(core_en), .O_BUS_CLK_EN(bus_en), .O_LOCAL_INTR_CLK_EN(lic_en),
        .O_EXEC_EN(exec_en), .O_SAVE_STATE(save), .O_MANAGEMENT_MODE(mgmt),
        .O_INTR_SERVICE(isrv), .O_THERMAL_HALT_N(halt_n), .O_TERM_PRESENT(term_p),
        .O_EDGE_RATE(edge_r), .O_IRQ(irq), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready));
    chipset_model u_chip (.i_clk(clk), .i_rst(rst), .i_ack_req(ack_req),
        .i_ack_code(ack_code), .i_delay(delay), .o_target_ready_n(target_ready_n_n),
        .o_last_code(last_code));
    ////////////////////////////////////////
    // Random snoop traffic and service pulse count
    always @(posedge clk) begin
        snoop <= 1'($random(seed));
        if (isrv === 1'b1) serviced <= serviced + 1;
    end
    task check_bit(input logic a, input logic e);
        checks++;
        if (a !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    task check_word(input logic [31:0] a, input logic [31:0] e);
        checks++;
        if (a !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    task report_and_stop;
        if (failures == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task cycles(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Expected strap bits of the status word
    function automatic logic [31:0] strap_bits(input logic t, input logic e);
        return {26'h0, e, t, 4'h0};
    endfunction
    task wr(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        // Each channel released at the edge that takes it
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge clk); while (bvalid !== 1'b1);
        check_word({30'h0, bresp}, {30'h0, pwr_seq_pkg::RESP_OK});
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        @(posedge clk);
        while (!arready) @(posedge clk);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        d = rdata;
        check_word({30'h0, rresp}, {30'h0, pwr_seq_pkg::RESP_OK});
        rready <= 1'b0;
        @(posedge clk);
    endtask
    ////////////////////////////////////////
    // Watchdog
    initial begin
        #500000;
        failures++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        int n;
        logic [31:0] r, m;
        term = 1'($random(seed));
        edge_s = 1'($random(seed));
        cycles(4);
        rst <= 1'b0;
        cycles(3);
        check_bit(term_p, term);
        check_bit(edge_r, edge_s);
        rd(pwr_seq_pkg::STAT_ADDR, r);
        check_word(r & 32'h30, strap_bits(term, edge_s));
        term <= ~term;
        cycles(3);
        check_bit(term_p, ~term);
        rd(pwr_seq_pkg::IRQM_ADDR, r);
        check_word(r, 32'h0);
        m = {27'h0, 5'($random(seed))} | 32'h1;
        wr(pwr_seq_pkg::IRQM_ADDR, m);
        rd(pwr_seq_pkg::IRQM_ADDR, r);
        check_word(r, m);
        slp_n <= 1'b0;
        cycles(8);
        check_bit(bus_en, 1'b1);
        slp_n <= 1'b1;
        delay <= 3'($random(seed));
        stop_n <= 1'b0;
        for (n = 0; n < 60 && core_en; n++) @(posedge clk);
        check_bit(core_en, 1'b0);
        check_word({30'h0, last_code}, {30'h0, pwr_seq_pkg::ACK_STOPGNT});
        check_bit(lic_en, 1'b1);
        cycles(2);
        check_bit(irq, 1'b1);
        rd(pwr_seq_pkg::IRQS_ADDR, r);
        check_word(r & 32'h1, 32'h1);
        cycles(2);
        check_bit(irq, 1'b0);
        intr <= 1'b1;
        cycles(2);
        intr <= 1'b0;
        slp_n <= 1'b0;
        for (n = 0; n < 60 && bus_en; n++) @(posedge clk);
        check_bit(bus_en, 1'b0);
        intr <= 1'b1;
        cycles(2);
        intr <= 1'b0;
        cycles(4);
        slp_n <= 1'b1;
        for (n = 0; n < 60 && !bus_en; n++) @(posedge clk);
        check_bit(core_en, 1'b0);
        m = 32'(serviced);
        stop_n <= 1'b1;
        for (n = 0; n < 60 && !exec_en; n++) @(posedge clk);
        cycles(6);
        check_bit(core_en, 1'b1);
        check_word(32'(serviced) - m, 32'h1);
        delay <= 3'h5;
        smi_n <= 1'b0;
        // Mode shows and the target has taken the acknowledge
        for (n = 0; n < 60 && !(mgmt && !ack_req); n++) @(posedge clk);
        check_word({30'h0, last_code}, {30'h0, pwr_seq_pkg::ACK_MGMT});
        smi_n <= 1'b1;
        wr(pwr_seq_pkg::CTRL_ADDR, 32'h1);
        cycles(2);
        check_bit(mgmt, 1'b0);
        hot <= 1'b1;
        for (n = 0; n < 60 && halt_n; n++) @(posedge clk);
        check_bit(exec_en, 1'b0);
        hot <= 1'b0;
        cycles(10);
        check_bit(halt_n, 1'b0);
        hot <= 1'b1;
        rst <= 1'b1;
        cycles(4);
        rst <= 1'b0;
        cycles(4);
        check_bit(halt_n, 1'b0);
        check_bit(exec_en, 1'b0);
        hot <= 1'b0;
        rst <= 1'b1;
        cycles(4);
        rst <= 1'b0;
        cycles(4);
        check_bit(halt_n, 1'b1);
        check_bit(exec_en, 1'b1);
        report_and_stop();
    end
endmodule // test_cpu_power_state_thermal_trip
